// ==== bench/pd_bmc_phy_asserts.sv ====
// Port checks for the baseband line coder.
// Assumes bind onto pd_bmc_baseband_phy; half UI from the defines.
`timescale 1ns/100ps
`include "pd_bmc_defines.svh"
module pd_bmc_phy_asserts
  import pd_bmc_pkg::*;
(
  // Clock, reset, orientation
  input wire logic    CORE_CLK,
  input wire logic    ARST_N,
  input wire logic    ORIENT,
  // Bit streams
  input wire tx_req_t TX_REQ,
  input wire logic    TX_ACK,
  input wire logic    TX_BUSY,
  input wire rx_bit_t RX_OUT,
  // Lines
  input wire logic    CC_LINE_A_IN,
  input wire logic    CC_LINE_A_OUT,
  input wire logic    CC_LINE_A_OE_N,
  input wire logic    CC_LINE_B_IN,
  input wire logic    CC_LINE_B_OUT,
  input wire logic    CC_LINE_B_OE_N
);
  localparam int HU  = `PD_HALF_UI_CYC;
  localparam int HU2 = 2 * HU;
  logic       lvl;
  logic       chg;
  logic       lvl_reg;
  logic [9:0] gap_reg;

  // ==========
  // Cycles since the last edge of the driven line
  assign lvl = CC_LINE_B_OE_N ? CC_LINE_A_OUT : CC_LINE_B_OUT;
  assign chg = lvl != lvl_reg;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lvl_reg <= 1'b0;
      gap_reg <= 10'h000;
    end else begin
      lvl_reg <= lvl;
      gap_reg <= !TX_BUSY ? 10'h000 : chg ? 10'h001 : gap_reg + 10'h001;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_frame_start;
    $rose(TX_BUSY) ##0 TX_ACK;
  endsequence
  sequence s_line_edge;
    TX_BUSY && chg;
  endsequence

  a_one_driver: assert property (CC_LINE_A_OE_N || CC_LINE_B_OE_N)
    else $error("both lines driven");
  a_idle_released: assert property (!TX_BUSY |-> CC_LINE_A_OE_N && CC_LINE_B_OE_N)
    else $error("line driven while idle");
  a_quiet_lines: assert property ((CC_LINE_A_OE_N |-> !CC_LINE_A_OUT) and (CC_LINE_B_OE_N |-> !CC_LINE_B_OUT))
    else $error("data on released line");
  a_lead_low: assert property (s_frame_start |-> (!lvl) [*8])
    else $error("frame does not open low");
  a_orient_pick: assert property (s_frame_start |-> CC_LINE_B_OE_N == !$past(ORIENT))
    else $error("wrong line for orientation");
  a_edge_spacing: assert property (s_line_edge |-> gap_reg == HU || gap_reg == HU2)
    else $error("edge off the half bit grid");
  a_close_hold: assert property ($fell(TX_BUSY) |-> gap_reg == HU)
    else $error("closing edge not held");
  a_rx_locked: assert property (RX_OUT.valid |-> RX_OUT.active)
    else $error("bit out while unlocked");
endmodule : pd_bmc_phy_asserts

bind pd_bmc_baseband_phy pd_bmc_phy_asserts u_chk (.*);

// ==== bench/pd_partner_model.sv ====
// Far-end controller: sends one coded frame of eight bits on request.
// Assumes the bench routes it to the selected line.
`timescale 1ns/100ps
`include "pd_bmc_defines.svh"
module pd_partner_model (
  // Control
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] pat,
  // Line drive
  output logic            drv,
  output logic            lvl
);
  localparam int HU = `PD_HALF_UI_CYC;

  // ==========
  // Released line shows the bias level, high
  initial begin
    drv = 1'b0;
    lvl = 1'b1;
    forever begin
      @(posedge clk iff go === 1'b1);
      #1 drv = 1'b1;
      lvl = 1'b0;
      for (int i = 0; i < 8; i++) begin
        repeat (HU) @(posedge clk);
        #1 lvl = !lvl;
        repeat (HU) @(posedge clk);
        #1 lvl = lvl ^ pat[i];
      end
      repeat (HU) @(posedge clk);
      #1 lvl = !lvl;
      repeat (HU) @(posedge clk);
      #1 drv = 1'b0;
      lvl = 1'b1;
    end
  end
endmodule : pd_partner_model

// ==== bench/tb.sv ====
// Bench for the baseband coder: transmit and receive frames.
// Assumes the partner only talks while the coder is idle.
`timescale 1ns/100ps
`include "pd_bmc_defines.svh"
module tb;
  import pd_bmc_pkg::*;
  localparam int HU = `PD_HALF_UI_CYC;
  logic       clk, arst_n, orient, go, p_drv, p_lvl;
  logic       ack, busy, a, b, a_out, a_oe_n, b_out, b_oe_n;
  logic [7:0] pat;
  logic [9:0] rx_sh;
  tx_req_t    req;
  rx_bit_t    rx;
  int         miscompares, n_compared;

  // ==========
  // Lines rest at the bias level when nobody drives
  assign a = !a_oe_n ? a_out : (p_drv && !orient) ? p_lvl : 1'b1;
  assign b = !b_oe_n ? b_out : (p_drv && orient) ? p_lvl : 1'b1;

  pd_bmc_baseband_phy u_dut (.CORE_CLK(clk), .ARST_N(arst_n),
    .ORIENT(orient), .TX_REQ(req), .TX_ACK(ack), .TX_BUSY(busy),
    .RX_OUT(rx), .CC_LINE_A_IN(a), .CC_LINE_A_OUT(a_out),
    .CC_LINE_A_OE_N(a_oe_n), .CC_LINE_B_IN(b), .CC_LINE_B_OUT(b_out),
    .CC_LINE_B_OE_N(b_oe_n));
  pd_partner_model u_partner (.clk(clk), .go(go), .pat(pat),
    .drv(p_drv), .lvl(p_lvl));

  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  always @(posedge clk) if (rx.valid === 1'b1) rx_sh <= {rx_sh[8:0], rx.data};

  task automatic check(input string what, input logic [9:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (ack !== 1'b1 && n < 1000);
    if (ack !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask : wait_ack

  task automatic t_tx(input logic o, input logic [3:0] bits);
    logic [9:0] exp, got;
    logic       l;
    orient = o;
    l = 1'b0;
    exp[0] = 1'b0;
    for (int i = 0; i < 4; i++) begin
      l = !l;
      exp[2*i+1] = l;
      l = l ^ bits[i];
      exp[2*i+2] = l;
    end
    exp[9] = !l;
    req = '{1'b1, bits[0], 1'b0};
    wait_ack();
    fork
      begin
        for (int i = 1; i < 4; i++) begin
          req = '{1'b1, bits[i], i == 3};
          wait_ack();
        end
        req = '0;
      end
      begin
        repeat (HU / 2) @(posedge clk);
        for (int k = 0; k < 10; k++) begin
          #1 got[k] = o ? b : a;
          repeat (HU) @(posedge clk);
        end
      end
    join
    repeat (HU) @(posedge clk);
    #1 check("tx levels", got, exp);
    check("tx release", 10'({busy, a_oe_n, b_oe_n}), 10'h003);
    $display("tx done");
  endtask : t_tx

  task automatic t_rx(input logic o, input logic [7:0] p);
    logic [7:0] r;
    r = {<<{p}};
    orient = o;
    pat = p;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    repeat (HU * 21) @(posedge clk);
    // Leading bits may be lost while the receiver locks
    #1 check("rx bits", 10'(rx_sh[5:0]), 10'(r[5:0]));
    check("rx unlocked", 10'(rx.active), 10'h000);
    $display("rx done");
  endtask : t_rx

  initial begin
    arst_n = 1'b0;
    orient = 1'b0;
    go = 1'b0;
    pat = 8'h00;
    req = '0;
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 t_tx(1'b0, 4'hB);
    t_tx(1'b1, 4'h4);
    t_rx(1'b0, 8'hA6);
    t_rx(1'b1, 8'h3C);
    results();
  end
endmodule : tb

// ==== rtl/pd_bmc_baseband_phy.sv ====
// Biphase mark encoder and decoder for the configuration-channel wire.
// Assumes a link layer feeding one bit per acknowledge and pad logic
// that resolves each line from its output and active-low enable.
//
// Overview of operation
// - Every transmitted bit period starts with a line transition.
// - A one bit adds a transition at mid period; zero does not.
// - Coding keeps running disparity within half a bit per packet.
// - Preamble begins by driving the line low before any edge.
// - After the final bit one closing edge lets the receiver clock it.
// - Traffic uses only the line chosen by detected cable orientation.
// - Line driven by tri-state driver with separate output enable.
// - Driver released to high impedance whenever nothing is sent.
// - Only one party transmits; all others stay high impedance.

`timescale 1ns/100ps
`include "pd_bmc_defines.svh"

module pd_bmc_baseband_phy
  import pd_bmc_pkg::*;
(
  // Clock and reset
  input  wire logic    CORE_CLK,
  input  wire logic    ARST_N,
  // Orientation: 0 selects line a, 1 selects line b
  input  wire logic    ORIENT,
  // Transmit bit stream
  input  wire tx_req_t TX_REQ,
  output logic         TX_ACK,
  output logic         TX_BUSY,
  // Receive bit stream
  output rx_bit_t      RX_OUT,
  // Configuration-channel line a
  input  wire logic    CC_LINE_A_IN,
  output logic         CC_LINE_A_OUT,
  output logic         CC_LINE_A_OE_N,
  // Configuration-channel line b
  input  wire logic    CC_LINE_B_IN,
  output logic         CC_LINE_B_OUT,
  output logic         CC_LINE_B_OE_N
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // Transmit sequencer
  localparam logic [`PD_CNT_W-1:0] HALF_LAST =
    `PD_CNT_W'(`PD_HALF_UI_CYC - 1);

  tx_state_t            state_reg, state_next;
  logic [`PD_CNT_W-1:0] half_cnt_reg, half_cnt_next;
  logic                 phase_reg, phase_next;
  logic                 bit_reg, bit_next;
  logic                 last_reg, last_next;
  logic                 level_reg, level_next;
  logic                 side_reg, side_next;
  logic                 ack_next;
  logic                 half_done;
  logic                 take_next_bit;

  assign half_done     = (half_cnt_reg == '0);
  assign take_next_bit = TX_REQ.valid && !last_reg;

  always_comb begin
    state_next    = state_reg;
    half_cnt_next = half_done ? HALF_LAST : half_cnt_reg - 1'b1;
    phase_next    = phase_reg;
    bit_next      = bit_reg;
    last_next     = last_reg;
    level_next    = level_reg;
    side_next     = side_reg;
    ack_next      = 1'b0;
    unique case (state_reg)
      TX_IDLE: begin
        half_cnt_next = HALF_LAST;
        level_next    = `PD_LEAD_LEVEL;
        if (TX_REQ.valid) begin
          state_next = TX_LEAD;
          bit_next   = TX_REQ.data;
          last_next  = TX_REQ.last;
          side_next  = ORIENT;
          ack_next   = 1'b1;
        end
      end
      TX_LEAD: begin
        level_next = `PD_LEAD_LEVEL;
        if (half_done) begin
          state_next = TX_BIT;
          phase_next = 1'b0;
          level_next = ~level_reg;
        end
      end
      TX_BIT: begin
        if (half_done && !phase_reg) begin
          phase_next = 1'b1;
          if (bit_reg) begin
            level_next = ~level_reg;
          end
        end else if (half_done) begin
          phase_next = 1'b0;
          level_next = ~level_reg;
          if (take_next_bit) begin
            bit_next  = TX_REQ.data;
            last_next = TX_REQ.last;
            ack_next  = 1'b1;
          end else begin
            state_next = TX_CLOSE;
          end
        end
      end
      TX_CLOSE: begin
        if (half_done) begin
          state_next = TX_IDLE;
          level_next = `PD_LEAD_LEVEL;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= TX_IDLE;
      half_cnt_reg <= '0;
      phase_reg    <= 1'b0;
      bit_reg      <= 1'b0;
      last_reg     <= 1'b0;
      level_reg    <= `PD_LEAD_LEVEL;
      side_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      half_cnt_reg <= half_cnt_next;
      phase_reg    <= phase_next;
      bit_reg      <= bit_next;
      last_reg     <= last_next;
      level_reg    <= level_next;
      side_reg     <= side_next;
    end
  end

  // ==========================================================
  // Pad drive: one line at a time, released when idle
  // Every transition toggles, so disparity never exceeds half a bit
  logic drive_next;
  logic a_oe_n_next;
  logic b_oe_n_next;

  assign drive_next  = (state_next != TX_IDLE);
  assign a_oe_n_next = !(drive_next && !side_next);
  assign b_oe_n_next = !(drive_next && side_next);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CC_LINE_A_OUT  <= 1'b0;
      CC_LINE_A_OE_N <= 1'b1;
      CC_LINE_B_OUT  <= 1'b0;
      CC_LINE_B_OE_N <= 1'b1;
      TX_ACK         <= 1'b0;
      TX_BUSY        <= 1'b0;
    end else begin
      CC_LINE_A_OUT  <= level_next & ~side_next;
      CC_LINE_A_OE_N <= a_oe_n_next;
      CC_LINE_B_OUT  <= level_next & side_next;
      CC_LINE_B_OE_N <= b_oe_n_next;
      TX_ACK         <= ack_next;
      TX_BUSY        <= drive_next;
    end
  end

  // ==========================================================
  // Receive decoder on the oriented line
  localparam logic [`PD_CNT_W-1:0] RX_QTR   = `PD_CNT_W'(`PD_RX_QUARTER_CYC);
  localparam logic [`PD_CNT_W-1:0] RX_3QTR  = `PD_CNT_W'(`PD_RX_3QUARTER_CYC);
  localparam logic [`PD_CNT_W-1:0] RX_TMOUT = `PD_CNT_W'(`PD_RX_TIMEOUT_CYC);

  logic                 rx_line;
  logic                 rx_prev_reg;
  logic                 rx_edge;
  logic                 rx_listen;
  logic [`PD_CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
  logic                 rx_mid_reg, rx_mid_next;
  logic                 rx_act_reg, rx_act_next;
  logic                 rx_valid_next;
  logic                 rx_bound;
  logic                 rx_mid_win;
  logic                 rx_tmout;

  assign rx_line    = ORIENT ? CC_LINE_B_IN : CC_LINE_A_IN;
  // Own transmission is not decoded; the wire belongs to us then
  assign rx_listen  = (state_reg == TX_IDLE);
  assign rx_edge    = rx_listen && (rx_line != rx_prev_reg);
  assign rx_bound   = rx_edge && (rx_cnt_reg >= RX_3QTR);
  assign rx_mid_win = rx_edge && (rx_cnt_reg >= RX_QTR)
                      && (rx_cnt_reg < RX_3QTR);
  assign rx_tmout   = (rx_cnt_reg >= RX_TMOUT) || !rx_listen;

  always_comb begin
    rx_cnt_next   = (rx_cnt_reg == RX_TMOUT) ? rx_cnt_reg
                                             : rx_cnt_reg + 1'b1;
    rx_mid_next   = rx_mid_reg;
    rx_act_next   = rx_act_reg;
    rx_valid_next = 1'b0;
    if (rx_tmout) begin
      rx_act_next = 1'b0;
      rx_mid_next = 1'b0;
    end
    if (rx_edge && !rx_act_reg) begin
      // First seen edge only sets timing, so a lost lead edge is harmless
      rx_act_next = 1'b1;
      rx_cnt_next = '0;
      rx_mid_next = 1'b0;
    end else if (rx_bound && rx_act_reg) begin
      // A boundary edge keeps the lock even on the timeout cycle
      rx_act_next   = 1'b1;
      rx_valid_next = 1'b1;
      rx_cnt_next   = '0;
      rx_mid_next   = 1'b0;
    end else if (rx_mid_win && rx_act_reg) begin
      rx_mid_next = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      // Idle bias reads high; avoids a false edge after reset
      rx_prev_reg <= 1'b1;
      rx_cnt_reg  <= RX_TMOUT;
      rx_mid_reg  <= 1'b0;
      rx_act_reg  <= 1'b0;
      RX_OUT      <= '0;
    end else begin
      rx_prev_reg  <= rx_line;
      rx_cnt_reg   <= rx_cnt_next;
      rx_mid_reg   <= rx_mid_next;
      rx_act_reg   <= rx_act_next;
      RX_OUT.valid <= rx_valid_next;
      RX_OUT.data  <= rx_valid_next ? rx_mid_reg : RX_OUT.data;
      RX_OUT.active <= rx_act_next;
    end
  end

endmodule : pd_bmc_baseband_phy

// ==== rtl/pd_bmc_defines.svh ====
// Timing constants for the baseband line coder.
// Assumes a single core clock; all counts derive from its period.
`ifndef PD_BMC_DEFINES_SVH
`define PD_BMC_DEFINES_SVH

// Core clock period in ns
`define PD_CLK_PERIOD_NS   10
// Half of one unit interval in ns (nominal bit rate, adjustable)
`define PD_HALF_UI_NS      1667
// Half unit interval in clock cycles, rounded up
`define PD_HALF_UI_CYC     ((`PD_HALF_UI_NS + `PD_CLK_PERIOD_NS - 1) / `PD_CLK_PERIOD_NS)
// Receiver windows, in cycles since the last boundary edge
`define PD_RX_QUARTER_CYC  (`PD_HALF_UI_CYC / 2)
`define PD_RX_3QUARTER_CYC ((`PD_HALF_UI_CYC * 3) / 2)
`define PD_RX_TIMEOUT_CYC  (`PD_HALF_UI_CYC * 3)
// Width of every cycle counter
`define PD_CNT_W           10
// Line level driven before the first encoded edge
`define PD_LEAD_LEVEL      1'b0

`endif

// ==== rtl/pd_bmc_pkg.sv ====
// Types shared by the baseband line coder and its users.
// Timing numbers live in pd_bmc_defines.svh.
package pd_bmc_pkg;

  // ==========================================================
  // Transmit request and receive result carriers
  typedef struct packed {
    logic valid;
    logic data;
    logic last;
  } tx_req_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic active;
  } rx_bit_t;

  // ==========================================================
  // Transmit sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_LEAD  = 2'b01,
    TX_BIT   = 2'b11,
    TX_CLOSE = 2'b10
  } tx_state_t;

endpackage : pd_bmc_pkg
